// ===== src/switch_array_pkg.sv
// shared constants and carrier types for the serial switch array
package switch_array_pkg;
   localparam int SWITCH_COUNT = 8;
   localparam int FIFO_DEPTH = 4;
   localparam logic [SWITCH_COUNT-1:0] STAGE_RESET = 8'h00;
   localparam logic [SWITCH_COUNT-1:0] LATCH_RESET = 8'h00;
   localparam int LAST_STAGE = SWITCH_COUNT - 1;

   // one serial sample as seen by the front of the shift path
   typedef struct packed
   {
      logic serialIn;
   } serial_word_t;

   // serial control pins of the array
   typedef struct packed
   {
      logic shiftClock;
      logic loadStrobe;
   } ctrl_pins_t;
endpackage

// ===== src/sample_fifo.sv
// small valid/ready fifo holding serial samples
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q;
   logic [AW-1:0] rdPtr_q;
   logic [AW:0] count_q;
   logic doWrite;
   logic doRead;

   // pointer step with wrap
   function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1))
      begin
         return '0;
      end
      return p + AW'(1);
   endfunction

   // handshake terms
   assign inReady = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;
   assign outData = mem[rdPtr_q];

   // storage
   always_ff @(posedge sys_clk)
   begin
      if (doWrite)
      begin
         mem[wrPtr_q] <= inData;
      end
   end

   // pointers and fill count
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (doWrite)
         begin
            wrPtr_q <= nextPtr(wrPtr_q);
         end
         if (doRead)
         begin
            rdPtr_q <= nextPtr(rdPtr_q);
         end
         count_q <= count_q + (AW+1)'(doWrite) - (AW+1)'(doRead);
      end
   end
endmodule

// ===== src/serial_switch_array.sv
// serial shift register, holding latch and switch drive of the array
`timescale 1ns/1ps
module serial_switch_array
   import switch_array_pkg::*;
#(
   parameter int WIDTH = switch_array_pkg::SWITCH_COUNT
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // serial control from the controller
   input wire switch_array_pkg::serial_word_t serialData,
   input wire logic serialValid,
   output logic serialReady,
   input wire switch_array_pkg::ctrl_pins_t ctrlPins,
   input wire logic clear_n,
   // switch drive and chain output
   output logic [WIDTH-1:0] analogSwitch,
   output logic chainOut
);
   import switch_array_pkg::*;

   // ---------------------------------------------
   // input buffering
   // ---------------------------------------------
   serial_word_t headWord;
   logic headValid;
   logic takeBit;
   logic [WIDTH-1:0] shiftStage_q;
   logic [WIDTH-1:0] latchBit_q;

   sample_fifo #(.WIDTH($bits(serial_word_t)), .DEPTH(FIFO_DEPTH)) inFifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .inValid(serialValid),
      .inReady(serialReady),
      .inData(serialData),
      .outValid(headValid),
      .outReady(takeBit),
      .outData(headWord)
   );

   // a bit is consumed only while shift level is active
   assign takeBit = headValid && ctrlPins.shiftClock && clear_n;

   // ---------------------------------------------
   // shift register
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shiftStage_q <= STAGE_RESET;
      end
      else if (!clear_n)
      begin
         shiftStage_q <= STAGE_RESET;
      end
      else if (takeBit)
      begin
         shiftStage_q <= {shiftStage_q[WIDTH-2:0], headWord.serialIn};
      end
   end

   // ---------------------------------------------
   // holding latch
   // ---------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         latchBit_q <= LATCH_RESET;
      end
      else if (!clear_n)
      begin
         latchBit_q <= LATCH_RESET;
      end
      else if (ctrlPins.loadStrobe)
      begin
         latchBit_q <= shiftStage_q;
      end
   end

   // outputs straight from flops
   assign analogSwitch = latchBit_q;
   assign chainOut = shiftStage_q[WIDTH-1];

   // ---------------------------------------------
   // fill tracking for the checks
   // ---------------------------------------------
   localparam int FILL_W = $clog2(WIDTH + 1);
   localparam logic [FILL_W-1:0] FILL_COUNT = FILL_W'(WIDTH);
   // shifts taken since the last clear, stops at a full register
   logic [FILL_W-1:0] shiftCount_q;

   // counts alongside the shift register, cleared with it
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shiftCount_q <= '0;
      end
      else if (!clear_n)
      begin
         shiftCount_q <= '0;
      end
      else if (takeBit && (shiftCount_q != FILL_COUNT))
      begin
         shiftCount_q <= shiftCount_q + FILL_W'(1);
      end
   end

   // ---------------------------------------------
   // assertions: shift path
   // ---------------------------------------------
   // a taken bit enters stage 1 and every stage moves up one
   a_shift_moves: assert property (@(posedge sys_clk) disable iff (!rst_n)
      takeBit |=> shiftStage_q == {$past(shiftStage_q[WIDTH-2:0]), $past(headWord.serialIn)})
      else $error("shift step wrong");

   // without a taken bit the stages keep their values
   a_shift_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clear_n && !takeBit) |=> $stable(shiftStage_q))
      else $error("stages changed without shift");

   // an active shift level with nothing queued leaves the stages alone
   a_empty_no_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clear_n && ctrlPins.shiftClock && !headValid) |=> $stable(shiftStage_q))
      else $error("stages moved with empty queue");

   // a low shift level never moves the stages
   a_level_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clear_n && !ctrlPins.shiftClock) |=> $stable(shiftStage_q))
      else $error("shift without active level");

   // ---------------------------------------------
   // assertions: holding latch and switches
   // ---------------------------------------------
   // an active load level copies the stages as they stood
   a_latch_loads: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clear_n && ctrlPins.loadStrobe) |=> latchBit_q == $past(shiftStage_q))
      else $error("latch did not load");

   // without a load the latch keeps its value
   a_latch_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clear_n && !ctrlPins.loadStrobe) |=> $stable(latchBit_q))
      else $error("latch changed without load");

   // switch drive only moves after a load or a clear
   a_switch_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $changed(analogSwitch) |-> ($past(ctrlPins.loadStrobe) || !$past(clear_n)))
      else $error("switch drive changed without load");

   // the latched pattern keeps its count of closed switches
   a_many_closed: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clear_n && ctrlPins.loadStrobe) ##1 1'b1
         |-> $countones(analogSwitch) == $countones($past(shiftStage_q)))
      else $error("latched pattern not preserved");

   // several set stages give several closed switches, no one-hot squeeze
   a_mix_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clear_n && ctrlPins.loadStrobe && ($countones(shiftStage_q) > 1)) |=> ($countones(analogSwitch) > 1))
      else $error("switch mix reduced");

   // ---------------------------------------------
   // assertions: clear, reset and chain output
   // ---------------------------------------------
   // a low clear zeroes stages and latch at the next edge
   a_clear_forces: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !clear_n |=> (shiftStage_q == STAGE_RESET) && (analogSwitch == LATCH_RESET))
      else $error("clear did not zero");

   // reset keeps every switch open and the chain output low
   a_reset_opens: assert property (@(posedge sys_clk)
      !rst_n |=> (analogSwitch == LATCH_RESET) && !chainOut)
      else $error("reset did not open switches");

   // the chain output takes the old seventh stage on a shift
   a_chain_last: assert property (@(posedge sys_clk) disable iff (!rst_n)
      takeBit |=> chainOut == $past(shiftStage_q[WIDTH-2]))
      else $error("chain output not last stage");

   // the chain output holds between shifts
   a_chain_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (clear_n && !takeBit) |=> $stable(chainOut))
      else $error("chain output moved without shift");

   // until a full register of shifts the chain output stays low
   a_chain_zero_fill: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (shiftCount_q != FILL_COUNT) |-> !chainOut)
      else $error("chain output early");

   // ---------------------------------------------
   // cover points for the main scenarios
   // ---------------------------------------------
   // every switch closed at once
   c_all_closed: cover property (@(posedge sys_clk) disable iff (!rst_n) &analogSwitch);

   // a partial mix of closed switches
   c_some_closed: cover property (@(posedge sys_clk) disable iff (!rst_n)
      $countones(analogSwitch) > 1 && !(&analogSwitch));

   // the input queue refusing a bit
   c_fifo_full: cover property (@(posedge sys_clk) disable iff (!rst_n) !serialReady);

   // a clear opening closed switches
   c_clear_after_load: cover property (@(posedge sys_clk) disable iff (!rst_n)
      (|analogSwitch) ##1 !clear_n);

   // the shift register filled since the last clear
   c_register_filled: cover property (@(posedge sys_clk) disable iff (!rst_n)
      takeBit && (shiftCount_q == FILL_COUNT - FILL_W'(1)));
endmodule

// ===== test/switch_ctrl_model.sv
// controller model driving serial bits, shift clock and load strobe
`timescale 1ns/1ps
module switch_ctrl_model
   import switch_array_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // serial drive toward the array
   output switch_array_pkg::serial_word_t serialData,
   output logic serialValid,
   input wire logic serialReady,
   output switch_array_pkg::ctrl_pins_t ctrlPins
);
   // idle levels at time zero
   initial
   begin
      serialData = '0;
      serialValid = 1'b0;
      ctrlPins = '0;
   end
   // offer n bits msb first, valid held across the burst, each bit held until the edge that takes it
   task automatic push(input logic [7:0] bits, input int n);
      serialValid = 1'b1;
      for (int i = n - 1; i >= 0; i--)
      begin
         serialData.serialIn = bits[i];
         while (serialReady !== 1'b1)
         begin
            @(posedge sys_clk);
            #1;
         end
         @(posedge sys_clk);
         #1;
      end
      serialValid = 1'b0;
      serialData.serialIn = ~serialData.serialIn; // released line shows no stale bit
      @(posedge sys_clk);
      #1;
   endtask
   // hold a level on the control pins for n cycles, then one idle edge
   task automatic pins(input ctrl_pins_t p, input int n);
      ctrlPins = p;
      repeat (n) @(posedge sys_clk);
      #1 ctrlPins = '0;
      @(posedge sys_clk);
      #1;
   endtask
endmodule

// ===== test/test_serial_switch_array.sv
// self-checking bench for the serial switch array
`timescale 1ns/1ps
module test_serial_switch_array;
   import switch_array_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clear_n = 1'b1;
   serial_word_t serialData;
   ctrl_pins_t ctrlPins;
   logic serialValid;
   logic serialReady;
   logic chainOut;
   logic [7:0] analogSwitch;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   // clock and hang guard
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   switch_ctrl_model u_ctrl (.sys_clk(sys_clk), .serialData(serialData), .serialValid(serialValid),
      .serialReady(serialReady), .ctrlPins(ctrlPins));
   serial_switch_array u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .serialData(serialData),
      .serialValid(serialValid), .serialReady(serialReady), .ctrlPins(ctrlPins), .clear_n(clear_n),
      .analogSwitch(analogSwitch), .chainOut(chainOut));
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // fill the fifo until refused, shift in halves, latch only on load
   task automatic test_pattern();
      u_ctrl.push(8'h0B, 4);
      check(serialReady, 16'h0000);
      u_ctrl.pins(2'h2, 4);
      check(analogSwitch, 16'h0000);
      check(chainOut, 16'h0000);
      u_ctrl.push(8'h05, 4);
      u_ctrl.pins(2'h2, 6);
      check(chainOut, 16'h0001);
      u_ctrl.pins(2'h1, 1);
      check(analogSwitch, 16'h00B5);
   endtask
   // all switches closed at once, then a clear opens all
   task automatic test_clear();
      repeat (8)
      begin
         u_ctrl.push(8'h01, 1);
         u_ctrl.pins(2'h2, 1);
      end
      u_ctrl.pins(2'h1, 1);
      check(analogSwitch, 16'h00FF);
      clear_n = 1'b0;
      @(posedge sys_clk);
      #1 clear_n = 1'b1;
      check({analogSwitch, chainOut}, 16'h0000);
   endtask
   // verdict and end of run
   task automatic finish_test();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      check({analogSwitch, chainOut, serialReady}, 16'h0001);
      test_pattern();
      test_clear();
      finish_test();
   end
endmodule
